//--- rtl/cbr_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 250 MHz node clock and an axi4-lite slave with 32-bit data
//
// How it works
// - after reset the default bus is active
// - pre-operational slave listens alternately on both buses
// - slave consumes the master heartbeat
// - slave heartbeats only on active bus
// - heartbeat loss: pre-operational first, then switch
// - no process data while pre-operational
// - optional emergency on old bus before switching
// - management message marks its bus active
// - silent listen period: toggle, heartbeat, listen again; no heartbeat is sent on a toggle, it keeps the producer period
// - stop toggling after toggle limit
// - selection ends once active bus found
// - found bus overwrites default bus setting
// - node identifier is seven bits wide
// - node identifier zero is not allowed
// - listen period counts consumer heartbeat times
// - eight-bit toggle counter readable as status
// - consumer entry: 16-bit node, 16-bit ms
`ifndef CBR_REGS_SVH
`define CBR_REGS_SVH

// ********************************************************
// register byte offsets
// ********************************************************
`define CBR_OFF_CTRL      8'h00
`define CBR_OFF_BDEF      8'h04
`define CBR_OFF_TLISTEN   8'h08
`define CBR_OFF_NTOGGLE   8'h0c
`define CBR_OFF_CTOGGLE   8'h10
`define CBR_OFF_CONSUMER  8'h14
`define CBR_OFF_PRODUCER  8'h18
`define CBR_OFF_STATUS    8'h1c

// ********************************************************
// field positions
// ********************************************************
`define CBR_CTRL_EN_BIT    0
`define CBR_CTRL_EMCY_BIT  1
`define CBR_CTRL_ID_LSB    8
`define CBR_CTRL_ID_MSB    14
`define CBR_CONS_TIME_MSB  15
`define CBR_CONS_NODE_LSB  16
`define CBR_CONS_NODE_MSB  31

// ********************************************************
// reset values
// ********************************************************
`define CBR_RST_CTRL      32'h0000_0100
`define CBR_RST_BDEF      8'h00
`define CBR_RST_TLISTEN   8'h03
`define CBR_RST_NTOGGLE   8'h04
`define CBR_RST_CONSUMER  32'h0000_0064
`define CBR_RST_PRODUCER  16'h0032

// ********************************************************
// timing
// ********************************************************
`define CBR_CLK_MHZ       250
`define CBR_MS_NS         1000000
`define CBR_CLK_NS        4
`define CBR_MS_CYCLES     (`CBR_MS_NS / `CBR_CLK_NS)

`endif

//--- rtl/cbr_pkg.sv
// types shared by the bus redundancy selector
// assumes cbr_regs.svh supplies the numbers
package cbr_pkg;
  // node communication state
  typedef enum logic [1:0] {CBR_ST_PREOP, CBR_ST_OPER, CBR_ST_LOSS} cbr_state_t;
  // bus identity: zero nominal, one redundant
  typedef logic cbr_bus_t;
endpackage

//--- rtl/cbr_tick_if.sv
// interface carrying a millisecond timer request and its expiry
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface cbr_tick_if;
  logic        restart;   // restart the timer
  logic [15:0] period_ms; // period in milliseconds
  logic        expire;    // one-cycle pulse at period end
  modport owner (output restart, output period_ms, input expire);
  modport timer (input restart, input period_ms, output expire);
endinterface

//--- rtl/cbr_ms_timer.sv
// periodic millisecond timer, pulses expire every period_ms
// assumes a period of zero means stopped
`timescale 1ns/10ps
`include "cbr_regs.svh"
module cbr_ms_timer
  import cbr_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  cbr_tick_if.timer   tick
);
  localparam logic [17:0] MS_CYC = 18'(`CBR_MS_CYCLES); // cycles per ms
  logic [17:0] sub_r;  // cycle count in the ms
  logic [15:0] ms_r;   // ms count in the period

  // ********************************************************
  // counting
  // ********************************************************
  // ms prescaler and period counter
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sub_r <= 18'h0;
      ms_r  <= 16'h0;
      tick.expire <= 1'b0;
    end
    else
    begin
      tick.expire <= 1'b0;
      if (tick.restart || tick.period_ms == 16'h0)
      begin
        sub_r <= 18'h0;
        ms_r  <= 16'h0;
      end
      else if (sub_r == MS_CYC - 18'h1)
      begin
        sub_r <= 18'h0;
        if (ms_r == tick.period_ms - 16'h1)
        begin
          ms_r <= 16'h0;
          tick.expire <= 1'b1;
        end
        else
          ms_r <= ms_r + 16'h1;
      end
      else
        sub_r <= sub_r + 18'h1;
    end
  end
endmodule

//--- rtl/cbr_selector.sv
// top of the bus redundancy selector for a slave on a dual can network
// assumes a can controller pair that flags received frames per bus and
// sends frames on request; registers reached over axi4-lite
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "cbr_regs.svh"
module cbr_selector
  import cbr_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  // axi4-lite slave
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  // can side: frame events from the controllers
  input  wire logic [1:0]  MHB_RX_IN,
  input  wire logic [1:0]  NMT_RX_IN,
  input  wire logic        NMT_START_IN,
  // can side: selection and transmit requests
  output logic             BUS_SEL_OUT,
  output logic             HB_TX_OUT,
  output logic             EMCY_TX_OUT,
  output logic             PDO_EN_OUT,
  output logic [6:0]       NODE_ID_OUT
);
  // ********************************************************
  // register file
  // ********************************************************
  logic [31:0] ctrl_r;      // enable, emergency option, node id
  logic        bdef_r;      // default bus
  logic [7:0]  tlisten_r;   // listen period in consumer times
  logic [7:0]  ntoggle_r;   // toggle limit
  logic [7:0]  ctoggle_r;   // toggles done
  logic [31:0] consumer_r;  // consumer node and timeout ms
  logic [15:0] producer_r;  // own heartbeat period ms
  logic        aw_r;        // write address held
  logic        w_r;         // write data held
  logic [7:0]  awaddr_r;    // latched write address
  logic [31:0] wdata_r;     // latched write data
  logic [3:0]  wstrb_r;     // latched strobes
  logic        wr_go;       // write performed this cycle
  logic        wr_ok;       // address mapped
  logic [6:0]  id_wr;       // candidate node id
  logic        found_pulse; // active bus identified
  cbr_bus_t    found_bus;   // bus that was identified

  // sync of pin inputs: first stage read only by second
  logic [1:0]  mhb_s1_r, mhb_s2_r;
  logic [1:0]  nmt_s1_r, nmt_s2_r;
  logic        start_s1_r, start_s2_r;

  // ********************************************************
  // input synchronisers
  // ********************************************************
  // two flops on every pin event line
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      {mhb_s1_r, mhb_s2_r} <= 4'h0;
      {nmt_s1_r, nmt_s2_r} <= 4'h0;
      {start_s1_r, start_s2_r} <= 2'h0;
    end
    else
    begin
      mhb_s1_r <= MHB_RX_IN;
      mhb_s2_r <= mhb_s1_r;
      nmt_s1_r <= NMT_RX_IN;
      nmt_s2_r <= nmt_s1_r;
      start_s1_r <= NMT_START_IN;
      start_s2_r <= start_s1_r;
    end
  end

  // ********************************************************
  // axi write channel
  // ********************************************************
  assign S_AXI_AWREADY_OUT = !aw_r && !S_AXI_BVALID_OUT;
  assign S_AXI_WREADY_OUT  = !w_r && !S_AXI_BVALID_OUT;
  assign wr_go = aw_r && w_r && !S_AXI_BVALID_OUT;
  assign wr_ok = awaddr_r <= `CBR_OFF_STATUS && awaddr_r[1:0] == 2'h0;
  assign id_wr = wdata_r[`CBR_CTRL_ID_MSB:`CBR_CTRL_ID_LSB];

  // address and data latched in either order
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= 8'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= 2'h0;
    end
    else
    begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      begin
        aw_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      begin
        w_r <= 1'b1;
        wdata_r <= S_AXI_WDATA_IN;
        wstrb_r <= S_AXI_WSTRB_IN;
      end
      if (wr_go)
      begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
        S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // register updates; status and toggle count are read only
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      ctrl_r <= `CBR_RST_CTRL;
      bdef_r <= 1'(`CBR_RST_BDEF);
      tlisten_r <= `CBR_RST_TLISTEN;
      ntoggle_r <= `CBR_RST_NTOGGLE;
      consumer_r <= `CBR_RST_CONSUMER;
      producer_r <= `CBR_RST_PRODUCER;
    end
    else
    begin
      if (found_pulse)
        bdef_r <= found_bus;
      if (wr_go && wstrb_r[0])
      begin
        unique case (awaddr_r)
          `CBR_OFF_BDEF:    bdef_r <= wdata_r[0];
          `CBR_OFF_TLISTEN: tlisten_r <= wdata_r[7:0];
          `CBR_OFF_NTOGGLE: ntoggle_r <= wdata_r[7:0];
          default: ;
        endcase
      end
      if (wr_go && awaddr_r == `CBR_OFF_CTRL && wstrb_r == 4'hf)
      begin
        // id zero would alias broadcast, so it is refused
        ctrl_r[1:0] <= wdata_r[1:0];
        if (id_wr != 7'h0)
          ctrl_r[`CBR_CTRL_ID_MSB:`CBR_CTRL_ID_LSB] <= id_wr;
      end
      if (wr_go && awaddr_r == `CBR_OFF_CONSUMER && wstrb_r == 4'hf)
        consumer_r <= wdata_r;
      if (wr_go && awaddr_r == `CBR_OFF_PRODUCER && wstrb_r[1:0] == 2'h3)
        producer_r <= wdata_r[15:0];
    end
  end

  // ********************************************************
  // axi read channel
  // ********************************************************
  assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
  cbr_state_t state_r;   // node state
  cbr_bus_t   bus_r;     // bus regarded active
  logic       search_r;  // selection procedure running

  // one read at a time, answer the cycle after arvalid
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h0;
      S_AXI_RRESP_OUT <= 2'h0;
    end
    else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
    begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RRESP_OUT <= 2'h0;
      unique case (S_AXI_ARADDR_IN)
        `CBR_OFF_CTRL:     S_AXI_RDATA_OUT <= ctrl_r;
        `CBR_OFF_BDEF:     S_AXI_RDATA_OUT <= {31'h0, bdef_r};
        `CBR_OFF_TLISTEN:  S_AXI_RDATA_OUT <= {24'h0, tlisten_r};
        `CBR_OFF_NTOGGLE:  S_AXI_RDATA_OUT <= {24'h0, ntoggle_r};
        `CBR_OFF_CTOGGLE:  S_AXI_RDATA_OUT <= {24'h0, ctoggle_r};
        `CBR_OFF_CONSUMER: S_AXI_RDATA_OUT <= consumer_r;
        `CBR_OFF_PRODUCER: S_AXI_RDATA_OUT <= {16'h0, producer_r};
        `CBR_OFF_STATUS:   S_AXI_RDATA_OUT <= {28'h0, search_r, bus_r, state_r};
        default:
        begin
          S_AXI_RDATA_OUT <= 32'h0;
          S_AXI_RRESP_OUT <= 2'h2;
        end
      endcase
    end
    else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
      S_AXI_RVALID_OUT <= 1'b0;
  end

  // ********************************************************
  // timers
  // ********************************************************
  cbr_tick_if cons_tick ();  // master heartbeat consumer time
  cbr_tick_if prod_tick ();  // own heartbeat period
  logic [7:0] periods_r;     // consumer times without traffic
  logic       mhb_seen;      // master heartbeat on active bus
  logic       nmt_seen;      // management message on some bus
  logic       nmt_bus;       // bus it came from
  logic       silent;        // listen period used up
  logic       can_toggle;    // toggle limit not yet reached
  logic       en;            // redundancy handling on

  assign en       = ctrl_r[`CBR_CTRL_EN_BIT];
  assign mhb_seen = mhb_s2_r[bus_r];
  assign nmt_seen = |nmt_s2_r;
  assign nmt_bus  = nmt_s2_r[1];
  assign silent   = cons_tick.expire && periods_r + 8'h1 >= tlisten_r;
  assign can_toggle = ctoggle_r < ntoggle_r;
  assign cons_tick.period_ms = consumer_r[`CBR_CONS_TIME_MSB:0];
  assign cons_tick.restart = mhb_seen || nmt_seen || found_pulse || silent;
  assign prod_tick.period_ms = producer_r;
  assign prod_tick.restart = 1'b0;

  cbr_ms_timer u_cons
  (
    .clk_in (CLK_IN),
    .rst_in (SYS_RST_IN),
    .tick   (cons_tick.timer)
  );

  cbr_ms_timer u_prod
  (
    .clk_in (CLK_IN),
    .rst_in (SYS_RST_IN),
    .tick   (prod_tick.timer)
  );

  // count elapsed consumer times with no traffic
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      periods_r <= 8'h0;
    else if (cons_tick.restart)
      periods_r <= 8'h0;
    else if (cons_tick.expire && periods_r != 8'hff)
      periods_r <= periods_r + 8'h1;
  end

  // ********************************************************
  // bus selection state machine
  // ********************************************************
  // one toggle fires per silent listen period; loss state lasts one
  // cycle so pdo stop precedes the bus change
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_r <= CBR_ST_PREOP;
      bus_r <= 1'b0;
      search_r <= 1'b0;
      ctoggle_r <= 8'h0;
      found_pulse <= 1'b0;
      found_bus <= 1'b0;
      EMCY_TX_OUT <= 1'b0;
    end
    else
    begin
      found_pulse <= 1'b0;
      EMCY_TX_OUT <= 1'b0;
      if (!en)
      begin
        bus_r <= bdef_r;
        state_r <= CBR_ST_PREOP;
        search_r <= 1'b1;
        ctoggle_r <= 8'h0;
      end
      else
      begin
        unique case (state_r)
          CBR_ST_OPER:
          begin
            if (silent)
            begin
              state_r <= CBR_ST_LOSS;
              EMCY_TX_OUT <= ctrl_r[`CBR_CTRL_EMCY_BIT];
            end
          end
          CBR_ST_LOSS:
          begin
            state_r <= CBR_ST_PREOP;
            bus_r <= !bus_r;
            search_r <= 1'b1;
            ctoggle_r <= 8'h0;
          end
          CBR_ST_PREOP:
          begin
            if (search_r && nmt_seen)
            begin
              bus_r <= nmt_bus;
              search_r <= 1'b0;
              found_pulse <= 1'b1;
              found_bus <= nmt_bus;
              ctoggle_r <= 8'h0;
            end
            else if (search_r && silent && can_toggle)
            begin
              bus_r <= !bus_r;
              ctoggle_r <= ctoggle_r + 8'h1;
            end
            // past the limit the bus is held and listening goes on
            if (start_s2_r && !search_r)
              state_r <= CBR_ST_OPER;
          end
        endcase
      end
    end
  end

  // ********************************************************
  // outputs to the can controllers
  // ********************************************************
  assign BUS_SEL_OUT = bus_r;
  assign NODE_ID_OUT = ctrl_r[`CBR_CTRL_ID_MSB:`CBR_CTRL_ID_LSB];
  assign PDO_EN_OUT  = state_r == CBR_ST_OPER;

  // own heartbeat pulse, sent on bus_r only
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      HB_TX_OUT <= 1'b0;
    else
      HB_TX_OUT <= en && prod_tick.expire;
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  loss_then_switch_a: assert property (state_r == CBR_ST_OPER && silent && en
    |=> state_r == CBR_ST_LOSS ##1 state_r == CBR_ST_PREOP && bus_r != $past(bus_r, 2))
    else $error("loss did not switch bus");
  // a bus change with process data still enabled would leak pdos mid-switch
  no_pdo_preop_a: assert property (en && bus_r != $past(bus_r) |-> !PDO_EN_OUT)
    else $error("pdo enabled during bus switch");
  nmt_marks_bus_a: assert property (en && state_r == CBR_ST_PREOP && search_r && nmt_seen
    |=> bus_r == $past(nmt_bus) && !search_r)
    else $error("nmt bus not adopted");
  bdef_update_a: assert property (found_pulse |=> bdef_r == $past(found_bus))
    else $error("default bus not updated");
  toggle_limit_a: assert property (ctoggle_r >= ntoggle_r && search_r && !nmt_seen && en
    && state_r == CBR_ST_PREOP |=> bus_r == $past(bus_r))
    else $error("toggled past limit");
  toggle_count_a: assert property (en && state_r == CBR_ST_PREOP && search_r && !nmt_seen
    && silent && can_toggle |=> ctoggle_r == $past(ctoggle_r) + 8'h1 && bus_r != $past(bus_r))
    else $error("toggle not counted");
  id_nonzero_a: assert property (NODE_ID_OUT != 7'h0)
    else $error("node id zero");
  reset_bus_a: assert property (!en |=> bus_r == $past(bdef_r) && ctoggle_r == 8'h0)
    else $error("default bus not taken");
  hb_enabled_a: assert property (HB_TX_OUT |-> $past(en))
    else $error("heartbeat while disabled");

  found_c: cover property (found_pulse);
  loss_c: cover property (state_r == CBR_ST_LOSS);
  toggle_c: cover property (ctoggle_r == 8'h2);
endmodule

//--- tb/cbr_far_nodes.sv
// far-side model: redundancy master and management traffic on two buses
// assumes the bench steers it through its control inputs
`timescale 1ns/10ps
module cbr_far_nodes #(
  parameter int HB_GAP = 64 // cycles between master heartbeats
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       hb_on_in,
  input  wire logic       hb_bus_in,
  input  wire logic       nmt_req_in,
  input  wire logic       nmt_bus_in,
  input  wire logic       start_req_in,
  output logic [1:0]      mhb_rx_out,
  output logic [1:0]      nmt_rx_out,
  output logic            nmt_start_out
);
  int gap_r; // heartbeat spacing count
  // ********************************************************
  // master heartbeat on the bus it calls active
  // ********************************************************
  // moving hb_bus_in stops the old bus before the new one starts
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      gap_r      <= 0;
      mhb_rx_out <= 2'h0;
    end
    else
    begin
      mhb_rx_out <= 2'h0;
      if (hb_on_in)
      begin
        gap_r <= (gap_r == HB_GAP - 1) ? 0 : gap_r + 1;
        if (gap_r == HB_GAP - 1)
          mhb_rx_out[hb_bus_in] <= 1'b1;
      end
    end
  // management frames and start command, one cycle each
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      nmt_rx_out    <= 2'h0;
      nmt_start_out <= 1'b0;
    end
    else
    begin
      nmt_rx_out    <= nmt_req_in ? (2'h1 << nmt_bus_in) : 2'h0;
      nmt_start_out <= start_req_in;
    end
endmodule

//--- tb/tb.sv
// self-checking bench for the bus redundancy selector
// assumes cbr_far_nodes as the far side and a 250 MHz clock
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  import cbr_pkg::*;
  logic        clk = 0, rst = 1;          // clock and reset
  logic [7:0]  awa = 0, ara = 0;          // axi addresses
  logic [31:0] wd = 0, rd;                // axi data
  logic [3:0]  ws = 0;                    // write strobes
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic        awr, wr_, bv, arr, rv;     // slave handshakes
  logic [1:0]  bresp, rresp, mhb, nmt;
  logic        nst, bsel, hbtx, emcy, pdo;
  logic [6:0]  nid, id;                   // node id seen and written
  logic        hb_on = 0, hb_bus = 0, nreq = 0, nbus = 0, sreq = 0, rb, mv;
  int          err_count = 0, samples_checked = 0, hb_cnt = 0, h0, n;
  int          seed = 32'h56aa;           // fixed seed keeps runs repeatable
  // ********************************************************
  // clock, heartbeat counter, instances
  // ********************************************************
  always #2 clk = ~clk;
  always @(posedge clk) if (hbtx === 1'b1) hb_cnt++;
  cbr_selector cbr_selector_i (.CLK_IN(clk), .SYS_RST_IN(rst),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wr_), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .MHB_RX_IN(mhb), .NMT_RX_IN(nmt),
    .NMT_START_IN(nst), .BUS_SEL_OUT(bsel), .HB_TX_OUT(hbtx), .EMCY_TX_OUT(emcy),
    .PDO_EN_OUT(pdo), .NODE_ID_OUT(nid));
  cbr_far_nodes cbr_far_nodes_i (.clk_in(clk), .rst_in(rst), .hb_on_in(hb_on),
    .hb_bus_in(hb_bus), .nmt_req_in(nreq), .nmt_bus_in(nbus), .start_req_in(sreq),
    .mhb_rx_out(mhb), .nmt_rx_out(nmt), .nmt_start_out(nst));
  // ********************************************************
  // bus tasks: handshakes sampled at the taking edge, released right after it
  // ********************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic gb;
    logic [1:0] r;
    gb = 0;
    r = 'x;
    @(posedge clk);
    awa <= a; wd <= d; ws <= s; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    for (int i = 0; i < 100 && !gb; i++)
    begin
      @(posedge clk);
      // values read here are those sampled at this edge
      if (awv === 1'b1 && awr === 1'b1) awv <= 1'b0;
      if (wv === 1'b1 && wr_ === 1'b1) wv <= 1'b0;
      gb = bv === 1'b1;
      if (gb) r = bresp;
      if (gb) br <= 1'b0;
    end
    `CHK("bresp", er, r)
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic gb;
    logic [1:0] r;
    logic [31:0] d;
    gb = 0;
    r = 'x;
    d = 'x;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    for (int i = 0; i < 100 && !gb; i++)
    begin
      @(posedge clk);
      if (arv === 1'b1 && arr === 1'b1) arv <= 1'b0;
      gb = rv === 1'b1;
      if (gb) {r, d} = {rresp, rd};
      if (gb) rr <= 1'b0;
    end
    `CHK("rresp", er, r)
    `CHK("rdata", e, d)
  endtask
  // one management frame on bus b, then time for the sync stages
  task automatic nmt_on(input logic b);
    @(posedge clk);
    nreq <= 1'b1;
    nbus <= b;
    @(posedge clk);
    nreq <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: the loss test needs about 800k cycles
  initial
  begin
    repeat (1000000) @(posedge clk);
    err_count++;
    end_sim;
  end
  // ********************************************************
  // main sequence
  // ********************************************************
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    `CHK("bus", 1'b0, bsel)
    `CHK("pdo", 1'b0, pdo)
    rdc(8'h00, 32'h100, 2'h0);
    rdc(8'h04, 32'h0, 2'h0);
    rdc(8'h08, 32'h3, 2'h0);
    rdc(8'h0c, 32'h4, 2'h0);
    rdc(8'h10, 32'h0, 2'h0);
    rdc(8'h14, 32'h64, 2'h0);
    rdc(8'h18, 32'h32, 2'h0);
    rdc(8'h20, 32'h0, 2'h2);
    wr(8'h20, 32'h5, 4'hf, 2'h2);
    $display("test reset done");
    // disabled node follows the default setting
    wr(8'h04, 32'h1, 4'h1, 2'h0);
    repeat (3) @(posedge clk);
    `CHK("bus", 1'b1, bsel)
    wr(8'h00, 32'h0, 4'hf, 2'h0);
    repeat (2) @(posedge clk);
    `CHK("id", 7'h01, nid)
    repeat (4)
    begin
      id = 7'($random(seed));
      if (id == 7'h00) id = 7'h5a;
      wr(8'h00, {17'h0, id, 8'h00}, 4'hf, 2'h0);
      repeat (2) @(posedge clk);
      `CHK("id", id, nid)
    end
    // enable with emergency option: search starts on the default bus
    wr(8'h00, {17'h0, id, 8'h03}, 4'hf, 2'h0);
    repeat (4) @(posedge clk);
    rdc(8'h1c, 32'hc, 2'h0);
    `CHK("pdo", 1'b0, pdo)
    rb = 1'($random(seed));
    nmt_on(rb);
    `CHK("bus", rb, bsel)
    rdc(8'h04, {31'h0, rb}, 2'h0);
    rdc(8'h1c, {29'h0, rb, 2'h0}, 2'h0);
    hb_bus <= rb;
    hb_on <= 1'b1;
    sreq <= 1'b1;
    @(posedge clk);
    sreq <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("pdo", 1'b1, pdo)
    $display("test select done");
    // short listen periods, one toggle allowed
    wr(8'h08, 32'h1, 4'h1, 2'h0);
    wr(8'h0c, 32'h1, 4'h1, 2'h0);
    wr(8'h14, 32'h0001_0001, 4'hf, 2'h0);
    wr(8'h18, 32'h1, 4'h3, 2'h0);
    repeat (200) @(posedge clk);
    `CHK("pdo", 1'b1, pdo)
    hb_on <= 1'b0;
    h0 = hb_cnt;
    for (n = 0; emcy !== 1'b1 && n < 300000; n++) @(negedge clk);
    `CHK("emcy", 1'b1, emcy)
    `CHK("early", 1'b1, n > 249000)
    `CHK("bus", rb, bsel)
    repeat (3) @(negedge clk);
    `CHK("bus", ~rb, bsel)
    `CHK("pdo", 1'b0, pdo)
    for (n = 0; bsel !== rb && n < 300000; n++) @(negedge clk);
    `CHK("bus", rb, bsel)
    `CHK("early", 1'b1, n > 249000)
    rdc(8'h10, 32'h1, 2'h0);
    mv = 1'b0;
    repeat (300000) @(negedge clk) if (bsel !== rb) mv = 1'b1;
    `CHK("moved", 1'b0, mv)
    `CHK("hb", 1'b1, hb_cnt > h0 + 1)
    nmt_on(rb);
    rdc(8'h10, 32'h0, 2'h0);
    $display("test loss done");
    end_sim;
  end
endmodule
